/* File: logic/isq_seq.sv */
// i2c master protocol sequencer with link-side event capture
`timescale 1ns/100ps
`default_nettype none
// Contract
// - transfers are chains of start, address, data, stop steps
// - state moves only on host command or serial unit interrupt
// - eight states; uninitialized accepts only initialize
// - seven events numbered zero to six
// - idle plus start command issues start, goes to start wait
// - start detected in start wait sends address, goes to address wait
// - address done in address waits leads to send, receive or stop
// - send done sends next byte or stop after last; code sends restart instead after the last byte when rd_len is nonzero
// - receive byte done stores byte, continues or ends reception
// - stop detected in stop wait releases bus, ends transfer
// - nack detected in any wait state runs nack processing
// - undefined event reports other error, takes no bus action
// - channel flag idle-class when unused, communicating during transfer
// - request refused while channel is communicating
// - channels independent, each with own flag
// - byte interrupt on ninth clock rise except last read byte
// - last read byte interrupt on eighth clock, answered with nack
// - each slave keeps its own device flag
module isq_seq #(
    parameter int num_dev = 4,
    parameter int depth = isq_pkg::fifo_depth_dflt
) (
    // clocks and reset
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic link_clk,
    // host commands
    input wire logic cmd_init,
    input wire logic cmd_start,
    input wire isq_pkg::isq_req_type cmd_req,
    input wire logic [$clog2(num_dev)-1:0] cmd_dev,
    // transmit data from host
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [7:0] tx_data,
    // received data to host
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [7:0] rx_data,
    // status
    output isq_pkg::isq_state_type state,
    output isq_pkg::isq_flag_type channel_busy_flag,
    output logic [3*num_dev-1:0] dev_flags,
    output logic req_refused,
    output logic err_other,
    // serial unit, link clock domain
    input wire logic bus_condition_irq,
    input wire logic [1:0] bus_condition_kind,
    input wire logic byte_done_irq,
    input wire logic [7:0] link_rx_byte,
    output logic [2:0] prim_cmd,
    output logic [7:0] prim_data
);
    // link-domain capture: toggle per irq, byte held stable with it
    typedef struct packed {
        logic tog;
        logic [2:0] ev;
        logic [7:0] byte_v;
        logic [1:0] cmd_s1;
        logic [1:0] cmd_s2;
    } isq_link_type;
    isq_link_type lk_q, lk_d;

    typedef struct packed {
        isq_pkg::isq_state_type st;
        isq_pkg::isq_flag_type chf;
        logic [3*num_dev-1:0] devf;
        logic [$clog2(num_dev)-1:0] dev;
        isq_pkg::isq_req_type req;
        logic [7:0] wcnt;
        logic [7:0] rcnt;
        logic [2:0] pcmd;
        logic [7:0] pdata;
        logic ptog;
        logic [2:0] ts1;
        logic [2:0] ts2;
        logic [2:0] ts3;
        logic rxv;
        logic [7:0] rxd;
        logic refused;
        logic err;
        logic txr;
    } isq_sys_type;
    isq_sys_type q, d;

    logic push;
    logic evt;
    logic [2:0] ev_num;
    logic fifo_v;
    logic pop;
    logic [7:0] fifo_d;

    // event decode on the serial unit side; condition kind 0 start, 1 stop, else nack
    always_comb
    begin
        lk_d = lk_q;
        lk_d.cmd_s1 = {q.ptog, 1'b0};
        lk_d.cmd_s2 = lk_q.cmd_s1;
        if (bus_condition_irq)
        begin
            lk_d.tog = !lk_q.tog;
            lk_d.ev = (bus_condition_kind == 2'h0) ? isq_pkg::event_start_detected :
                      (bus_condition_kind == 2'h1) ? isq_pkg::event_stop_detected :
                      isq_pkg::event_nack_detected;
        end
        else if (byte_done_irq)
        begin
            // byte timing (9th or 8th clock rise) is the serial unit's
            lk_d.tog = !lk_q.tog;
            lk_d.ev = isq_pkg::event_address_done;
            lk_d.byte_v = link_rx_byte;
        end
    end

    always_ff @(posedge link_clk or negedge resetn)
    begin
        if (!resetn)
            lk_q <= '0;
        else
            lk_q <= lk_d;
    end

    // irq classes share one number; state decides address, send or receive
    assign evt = q.ts3[0] != q.ts2[0];
    assign ev_num = (q.st == isq_pkg::state_tx_wait && lk_q.ev == isq_pkg::event_address_done)
        ? isq_pkg::event_send_done : lk_q.ev;

    // sequencer step
    always_comb
    begin
        d = q;
        d.ts1 = {2'b00, lk_q.tog};
        d.ts2 = q.ts1;
        d.ts3 = q.ts2;
        d.rxv = q.rxv && !rx_ready;
        if (pop)
        begin
            d.rxv = 1'b1;
            d.rxd = fifo_d;
        end
        d.refused = 1'b0;
        d.err = 1'b0;
        push = 1'b0;
        d.txr = 1'b0;
        if (cmd_init)
        begin
            if (q.st == isq_pkg::state_uninit)
            begin
                d.st = isq_pkg::state_idle;
                d.chf = isq_pkg::flag_idle;
                for (int i = 0; i < num_dev; i++)
                    d.devf[3*i +: 3] = isq_pkg::flag_idle;
            end
            else
                d.err = 1'b1;
        end
        else if (cmd_start)
        begin
            if (q.chf == isq_pkg::flag_comm)
                d.refused = 1'b1;
            else if (q.st == isq_pkg::state_idle)
            begin
                d.st = isq_pkg::state_start_wait;
                d.chf = isq_pkg::flag_comm;
                d.dev = cmd_dev;
                d.devf[3*cmd_dev +: 3] = isq_pkg::flag_comm;
                d.req = cmd_req;
                d.wcnt = isq_pkg::rst_count;
                d.rcnt = isq_pkg::rst_count;
                d.pcmd = isq_pkg::prim_start;
                d.ptog = !q.ptog;
            end
            else
                d.err = 1'b1;
        end
        else if (evt)
        begin
            if (ev_num == isq_pkg::event_nack_detected &&
                q.st != isq_pkg::state_uninit && q.st != isq_pkg::state_idle)
            begin
                d.st = isq_pkg::state_idle;
                d.chf = isq_pkg::flag_nack;
                d.devf[3*q.dev +: 3] = isq_pkg::flag_nack;
                d.pcmd = isq_pkg::prim_stop;
                d.ptog = !q.ptog;
            end
            else
            begin
                case (q.st)
                isq_pkg::state_start_wait:
                    if (ev_num == isq_pkg::event_start_detected)
                    begin
                        // write phase first, restart when writes are done
                        d.pcmd = isq_pkg::prim_send;
                        d.ptog = !q.ptog;
                        if (q.req.wr_len != 8'h00 && q.wcnt == 8'h00)
                        begin
                            d.pdata = {q.req.addr, 1'b0};
                            d.st = isq_pkg::state_addr_w_wait;
                        end
                        else
                        begin
                            d.pdata = {q.req.addr, 1'b1};
                            d.st = isq_pkg::state_addr_r_wait;
                        end
                    end
                    else
                        d.err = 1'b1;
                isq_pkg::state_addr_w_wait, isq_pkg::state_tx_wait:
                    if (ev_num == isq_pkg::event_address_done ||
                        ev_num == isq_pkg::event_send_done)
                    begin
                        d.ptog = !q.ptog;
                        if (q.wcnt != q.req.wr_len && tx_valid)
                        begin
                            d.txr = 1'b1; // taken flag registered, port comes from a flop
                            d.pcmd = isq_pkg::prim_send;
                            d.pdata = tx_data;
                            d.wcnt = q.wcnt + 8'h01;
                            d.st = isq_pkg::state_tx_wait;
                        end
                        else if (q.req.rd_len != 8'h00)
                        begin
                            d.pcmd = isq_pkg::prim_restart; // combined transfer
                            d.wcnt = q.req.wr_len;
                            d.st = isq_pkg::state_start_wait;
                        end
                        else
                        begin
                            // a starved tx stream with no read phase also ends with stop
                            d.pcmd = isq_pkg::prim_stop;
                            d.st = isq_pkg::state_stop_wait;
                        end
                    end
                    else
                        d.err = 1'b1;
                isq_pkg::state_addr_r_wait, isq_pkg::state_rx_wait:
                    if (ev_num == isq_pkg::event_address_done)
                    begin
                        d.ptog = !q.ptog;
                        if (q.st == isq_pkg::state_rx_wait)
                        begin
                            push = 1'b1; // overflow drops byte, fifo is 16 deep
                            d.rcnt = q.rcnt + 8'h01;
                        end
                        if (q.st == isq_pkg::state_rx_wait && q.rcnt + 8'h01 == q.req.rd_len)
                        begin
                            d.pcmd = isq_pkg::prim_stop;
                            d.st = isq_pkg::state_stop_wait;
                        end
                        else
                        begin
                            // last byte gets nack and early irq
                            d.pcmd = (d.rcnt + 8'h01 == q.req.rd_len) ?
                                isq_pkg::prim_recv_nack : isq_pkg::prim_recv_ack;
                            d.st = isq_pkg::state_rx_wait;
                        end
                    end
                    else
                        d.err = 1'b1;
                isq_pkg::state_stop_wait:
                    if (ev_num == isq_pkg::event_stop_detected)
                    begin
                        d.st = isq_pkg::state_idle;
                        d.chf = isq_pkg::flag_finish;
                        d.devf[3*q.dev +: 3] = isq_pkg::flag_finish;
                        d.pcmd = isq_pkg::prim_none;
                        d.ptog = !q.ptog;
                    end
                    else
                        d.err = 1'b1;
                default:
                    d.err = 1'b1;
                endcase
            end
        end
    end

    isq_fifo #(
        .width(8),
        .depth(depth)
    ) u_rx_fifo (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .in_valid(push),
        .in_ready(),
        .in_data(lk_q.byte_v),
        .out_valid(fifo_v),
        .out_ready(pop),
        .out_data(fifo_d)
    );
    // a byte waits in the fifo until the output register is free
    assign pop = fifo_v && (!q.rxv || rx_ready);

    // single register stage so outputs come from flops
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            q <= '0;
            q.st <= isq_pkg::state_uninit;
            q.chf <= isq_pkg::flag_no_init;
        end
        else
            q <= d;
    end

    // primitive command held in sys domain; the toggle synchronised above (lk cmd_s2)
    // drives no output, so the serial unit finds a new command by its change
    assign state = q.st;
    assign channel_busy_flag = q.chf; // one instance per channel
    assign dev_flags = q.devf;
    assign req_refused = q.refused;
    assign err_other = q.err;
    assign rx_valid = q.rxv;
    assign rx_data = q.rxd;
    assign prim_cmd = q.pcmd;
    assign prim_data = q.pdata;
    assign tx_ready = q.txr;
endmodule // isq_seq

// synchronous fifo with valid/ready on both sides
module isq_fifo #(
    parameter int width = 8,
    parameter int depth = 16
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [width-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [width-1:0] out_data
);
    localparam int aw = $clog2(depth);
    logic [width-1:0] mem [depth];
    logic [aw:0] wr_q;
    logic [aw:0] rd_q;
    logic full;
    logic empty;

    // extra pointer bit tells full from empty
    assign full = (wr_q[aw] != rd_q[aw]) && (wr_q[aw-1:0] == rd_q[aw-1:0]);
    assign empty = (wr_q == rd_q);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_q[aw-1:0]];

    // pointers
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wr_q <= '0;
            rd_q <= '0;
        end
        else
        begin
            if (in_valid && !full)
                wr_q <= wr_q + 1'b1;
            if (out_ready && !empty)
                rd_q <= rd_q + 1'b1;
        end
    end

    // storage has no reset, only written entries are read
    always_ff @(posedge sys_clk)
    begin
        if (in_valid && !full)
            mem[wr_q[aw-1:0]] <= in_data;
    end
endmodule // isq_fifo
`default_nettype wire

/* File: logic/isq_pkg.sv */
// shared constants and types for the i2c protocol sequencer
package isq_pkg;
    // sequencer states, one-hot, bit index equals documented state number
    typedef enum logic [7:0] {
        state_uninit = 8'h01,
        state_idle = 8'h02,
        state_start_wait = 8'h04,
        state_addr_w_wait = 8'h08,
        state_addr_r_wait = 8'h10,
        state_tx_wait = 8'h20,
        state_rx_wait = 8'h40,
        state_stop_wait = 8'h80
    } isq_state_type;
    // event numbers
    localparam logic [2:0] event_initialize = 3'h0;
    localparam logic [2:0] event_start_command = 3'h1;
    localparam logic [2:0] event_start_detected = 3'h2;
    localparam logic [2:0] event_address_done = 3'h3;
    localparam logic [2:0] event_send_done = 3'h4;
    localparam logic [2:0] event_stop_detected = 3'h5;
    localparam logic [2:0] event_nack_detected = 3'h6;
    // channel / device flag values
    typedef enum logic [2:0] {
        flag_no_init = 3'h0,
        flag_idle = 3'h1,
        flag_finish = 3'h2,
        flag_nack = 3'h3,
        flag_comm = 3'h4,
        flag_error = 3'h5
    } isq_flag_type;
    // transfer request from host
    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] wr_len;
        logic [7:0] rd_len;
    } isq_req_type;
    // bus primitive commands toward the serial unit
    localparam logic [2:0] prim_none = 3'h0;
    localparam logic [2:0] prim_start = 3'h1;
    localparam logic [2:0] prim_restart = 3'h2;
    localparam logic [2:0] prim_send = 3'h3;
    localparam logic [2:0] prim_recv_ack = 3'h4;
    localparam logic [2:0] prim_recv_nack = 3'h5;
    localparam logic [2:0] prim_stop = 3'h6;
    // reset values
    localparam logic [7:0] rst_count = 8'h00;
    localparam int fifo_depth_dflt = 16;
    localparam int data_width_dflt = 8;
endpackage : isq_pkg

/* File: logic/isq_fifo.sv */
// receive fifo module is kept beside the sequencer, in isq_seq.sv

/* File: verification/isq_seq_asserts.sv */
// port assertions for the i2c protocol sequencer
`timescale 1ns/100ps
`default_nettype none
module isq_seq_asserts (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // host commands
    input wire logic cmd_init,
    input wire logic cmd_start,
    // status
    input wire isq_pkg::isq_state_type state,
    input wire isq_pkg::isq_flag_type channel_busy_flag,
    input wire logic req_refused,
    input wire logic err_other,
    input wire logic [2:0] prim_cmd
);
    logic busy;
    logic in_wait;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // start wait up to receive wait; stop wait is left out though it keeps the comm flag
    assign busy = channel_busy_flag == isq_pkg::flag_comm;
    assign in_wait = (state & 8'h7c) != 8'h00;
    sequence s_stop_wait; state == isq_pkg::state_stop_wait; endsequence
    sequence s_back_idle; state == isq_pkg::state_idle; endsequence

    a_state_one_hot: assert property ($onehot(state))
        else $error("state not one-hot");
    a_uninit_holds: assert property (state == isq_pkg::state_uninit && !cmd_init |=>
        state == isq_pkg::state_uninit) else $error("left uninit without init");
    a_init_to_idle: assert property (state == isq_pkg::state_uninit && cmd_init |=>
        state == isq_pkg::state_idle && channel_busy_flag == isq_pkg::flag_idle)
        else $error("init did not reach idle");
    a_start_issue: assert property (state == isq_pkg::state_idle && cmd_start && !cmd_init
        |=> state == isq_pkg::state_start_wait && busy ##[0:6] prim_cmd == isq_pkg::prim_start)
        else $error("start command not carried out");
    a_busy_refuse: assert property (busy && cmd_start && !cmd_init |=>
        req_refused && $stable(state)) else $error("busy start not refused");
    a_refuse_cause: assert property (req_refused |-> $past(busy))
        else $error("refusal while not busy");
    a_other_still: assert property (err_other |-> $stable(state))
        else $error("state moved on error");
    a_wait_busy: assert property (in_wait |-> busy)
        else $error("flag not busy during transfer");
    a_idle_class: assert property (state == isq_pkg::state_idle |-> channel_busy_flag inside
        {isq_pkg::flag_idle, isq_pkg::flag_finish, isq_pkg::flag_nack})
        else $error("idle with busy-class flag");
    a_stop_to_idle: assert property (s_stop_wait ##1 s_back_idle |-> channel_busy_flag
        inside {isq_pkg::flag_finish, isq_pkg::flag_nack}) else $error("bad flag after end");
endmodule // isq_seq_asserts

bind isq_seq isq_seq_asserts isq_seq_asserts_i (.sys_clk(sys_clk), .resetn(resetn),
    .cmd_init(cmd_init), .cmd_start(cmd_start), .state(state),
    .channel_busy_flag(channel_busy_flag), .req_refused(req_refused),
    .err_other(err_other), .prim_cmd(prim_cmd));
`default_nettype wire

/* File: verification/isq_slave_model.sv */
// serial unit and slave devices answering bus primitives
`timescale 1ns/100ps
`default_nettype none
module isq_slave_model (
    // link clock
    input wire logic link_clk,
    // primitives from the sequencer
    input wire logic [2:0] prim_cmd,
    input wire logic [7:0] prim_data,
    // scenario controls
    input wire logic slow,
    input wire logic nack_en,
    // interrupt side
    output logic bus_condition_irq,
    output logic [1:0] bus_condition_kind,
    output logic byte_done_irq,
    output logic [7:0] link_rx_byte
);
    logic [10:0] last = 11'h000;
    logic [10:0] log_q[$];
    logic [7:0] rx_byte = 8'hc0;
    logic addr_next = 1'b0;
    initial {bus_condition_irq, byte_done_irq, bus_condition_kind, link_rx_byte} = '0;
    // new primitive found by change only, so back-to-back repeats must differ
    always
    begin
        @(posedge link_clk);
        if ({prim_cmd, prim_data} != last && prim_cmd != isq_pkg::prim_none)
        begin
            last = {prim_cmd, prim_data};
            log_q.push_back({prim_cmd, prim_cmd == isq_pkg::prim_send ? prim_data : 8'h00});
            repeat (slow ? 12 : 3) @(posedge link_clk);
            if (last[10:8] inside {isq_pkg::prim_start, isq_pkg::prim_restart})
            begin
                bus_condition_irq <= 1'b1;
                bus_condition_kind <= 2'h0;
                addr_next = 1'b1;
            end
            else if (last[10:8] == isq_pkg::prim_stop)
            begin
                bus_condition_irq <= 1'b1;
                bus_condition_kind <= 2'h1;
            end
            else if (addr_next && nack_en)
            begin
                bus_condition_irq <= 1'b1; // address refused by the slave
                bus_condition_kind <= 2'h2;
                addr_next = 1'b0;
            end
            else
            begin
                byte_done_irq <= 1'b1; // same delay for every byte kind; eighth or ninth clock not modelled
                link_rx_byte <= rx_byte;
                rx_byte = rx_byte + (last[10:8] == isq_pkg::prim_send ? 8'h00 : 8'h01);
                addr_next = 1'b0;
            end
            @(posedge link_clk);
            // lines not held after the pulse: show inverse, never last value
            bus_condition_irq <= 1'b0;
            byte_done_irq <= 1'b0;
            bus_condition_kind <= ~bus_condition_kind;
            link_rx_byte <= ~link_rx_byte;
        end
    end
endmodule // isq_slave_model
`default_nettype wire

/* File: verification/isq_seq_tb_top.sv */
// testbench for the i2c protocol sequencer
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; $display("ERROR %0t got %h exp %h", $time, a, b); end end
module isq_seq_tb_top;
    logic sys_clk = 0, link_clk = 0, resetn = 0;
    logic cmd_init = 0, cmd_start = 0, tx_valid = 0, rx_ready = 0, slow = 0, nack_en = 0;
    logic tx_ready, rx_valid, req_refused, err_other, bc_irq, bd_irq;
    logic [7:0] tx_data = 8'h00, rx_data, rx_byte, prim_data;
    logic [1:0] bc_kind, seen;
    logic [2:0] prim_cmd, tx_cnt = 3'h0;
    logic [1:0] cmd_dev = 2'h0;
    logic [11:0] dev_flags;
    isq_pkg::isq_req_type cmd_req = '0;
    isq_pkg::isq_state_type state;
    isq_pkg::isq_flag_type flag;
    int error_cnt = 0, checks_done = 0;

    always #4 sys_clk = ~sys_clk;
    // link clock free running; its edges meet a sys_clk edge every 60 ns
    always #7.5 link_clk = ~link_clk;

    isq_seq isq_seq_i (.sys_clk(sys_clk), .resetn(resetn), .link_clk(link_clk),
        .cmd_init(cmd_init), .cmd_start(cmd_start), .cmd_req(cmd_req), .cmd_dev(cmd_dev),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_data(rx_data), .state(state), .channel_busy_flag(flag),
        .dev_flags(dev_flags), .req_refused(req_refused), .err_other(err_other),
        .bus_condition_irq(bc_irq), .bus_condition_kind(bc_kind), .byte_done_irq(bd_irq),
        .link_rx_byte(rx_byte), .prim_cmd(prim_cmd), .prim_data(prim_data));
    isq_slave_model isq_slave_model_i (.link_clk(link_clk), .prim_cmd(prim_cmd),
        .prim_data(prim_data), .slow(slow), .nack_en(nack_en), .bus_condition_irq(bc_irq),
        .bus_condition_kind(bc_kind), .byte_done_irq(bd_irq), .link_rx_byte(rx_byte));

    // write byte source: next byte offered once the last is taken
    always @(posedge sys_clk)
        if (tx_valid && tx_ready)
        begin
            tx_data <= tx_data + 8'h11;
            tx_cnt <= tx_cnt - 3'h1;
            tx_valid <= tx_cnt > 3'h1;
        end

    task automatic end_of_test;
        if (error_cnt == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // one-cycle command; refusal and error pulses caught in a short window
    task automatic pulse_cmd(input logic init);
        seen = 2'b00;
        @(posedge sys_clk);
        cmd_init <= init;
        cmd_start <= !init;
        @(posedge sys_clk);
        cmd_init <= 1'b0;
        cmd_start <= 1'b0;
        repeat (3)
        begin
            #1;
            seen = seen | {req_refused, err_other};
            @(posedge sys_clk);
        end
    endtask

    task automatic wait_st(input isq_pkg::isq_state_type s);
        int n;
        n = 0;
        while (state !== s && n < 600)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        `CHK(state, s)
    endtask

    // entries are {primitive, sent byte}
    task automatic chk_log(input logic [10:0] ex[$]);
        `CHK(isq_slave_model_i.log_q.size(), ex.size())
        foreach (ex[i]) `CHK(isq_slave_model_i.log_q[i], ex[i])
        isq_slave_model_i.log_q.delete();
    endtask

    task automatic t_init;
        pulse_cmd(1'b0);
        `CHK(seen, 2'b01)
        `CHK(state, isq_pkg::state_uninit)
        pulse_cmd(1'b1);
        wait_st(isq_pkg::state_idle);
        `CHK(flag, isq_pkg::flag_idle)
        pulse_cmd(1'b1);
        `CHK(seen, 2'b01)
        `CHK(state, isq_pkg::state_idle)
    endtask

    task automatic t_write;
        slow <= 1'b1;
        cmd_req <= '{addr: 7'h2a, wr_len: 8'h02, rd_len: 8'h00};
        cmd_dev <= 2'h2;
        tx_data <= 8'h31;
        tx_cnt <= 3'h2;
        tx_valid <= 1'b1;
        pulse_cmd(1'b0);
        wait_st(isq_pkg::state_start_wait);
        `CHK(flag, isq_pkg::flag_comm)
        `CHK(dev_flags[8:6], isq_pkg::flag_comm)
        pulse_cmd(1'b0);
        `CHK(seen, 2'b10)
        wait_st(isq_pkg::state_tx_wait);
        wait_st(isq_pkg::state_stop_wait);
        wait_st(isq_pkg::state_idle);
        `CHK(flag, isq_pkg::flag_finish)
        `CHK(dev_flags[8:6], isq_pkg::flag_finish)
        `CHK(dev_flags[5:3], isq_pkg::flag_idle)
        chk_log('{11'h100, 11'h354, 11'h331, 11'h342, 11'h600});
    endtask

    task automatic t_combined;
        slow <= 1'b0;
        rx_ready <= 1'b0;
        cmd_req <= '{addr: 7'h15, wr_len: 8'h01, rd_len: 8'h02};
        cmd_dev <= 2'h1;
        tx_data <= 8'h77;
        tx_cnt <= 3'h1;
        tx_valid <= 1'b1;
        pulse_cmd(1'b0);
        wait_st(isq_pkg::state_addr_r_wait);
        wait_st(isq_pkg::state_rx_wait);
        wait_st(isq_pkg::state_idle);
        `CHK(flag, isq_pkg::flag_finish)
        `CHK({rx_valid, rx_data}, 9'h1c0)
        @(posedge sys_clk) rx_ready <= 1'b1;
        @(posedge sys_clk) rx_ready <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 `CHK({rx_valid, rx_data}, 9'h1c1)
        chk_log('{11'h100, 11'h32a, 11'h377, 11'h200, 11'h32b, 11'h400, 11'h500, 11'h600});
    endtask

    task automatic t_nack;
        nack_en <= 1'b1;
        rx_ready <= 1'b1;
        cmd_req <= '{addr: 7'h11, wr_len: 8'h01, rd_len: 8'h00};
        pulse_cmd(1'b0);
        wait_st(isq_pkg::state_idle);
        `CHK(flag, isq_pkg::flag_nack)
        // stop primitive reaches the model on a later link edge
        repeat (4) @(posedge sys_clk);
        chk_log('{11'h100, 11'h322, 11'h600});
    endtask

    initial
    begin
        #200us;
        error_cnt++;
        end_of_test();
    end

    initial
    begin
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        t_init();
        t_write();
        t_combined();
        t_nack();
        end_of_test();
    end
endmodule // isq_seq_tb_top
`default_nettype wire
